/* hdl/mlp_pin_sync.sv */
// Purpose: two-flop synchronisers for line pins and PHY clock edge finding
// Assumes: PHY clocks far slower than sys_clk
// Notes: edge detection reads only the second synchroniser stage
`timescale 1ns/100ps
module mlp_pin_sync #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic miiTxClk,
    input wire logic miiRxClk,
    input wire logic [3:0] miiRxd,
    input wire logic miiRxDv,
    input wire logic miiCrs,
    input wire logic miiCol,
    input wire logic serialRxData,
    input wire logic serialCrs,
    input wire logic serialCol,
    mlp_link_if.src lnk
);
    logic [WIDTH-1:0] rawPins;
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;
    logic [1:0] clkPrev_q;

    assign rawPins = {miiTxClk, miiRxClk, miiRxd, miiRxDv, miiCrs, miiCol,
                      serialRxData, serialCrs, serialCol};

    for (genvar i = 0; i < WIDTH; i++) begin : g_sync
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                stable_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= rawPins[i];
                stable_q[i] <= meta_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clkPrev_q <= 2'h0;
        end else begin
            clkPrev_q <= stable_q[WIDTH-1:WIDTH-2];
        end
    end

    assign lnk.txClkRise = stable_q[WIDTH-1] & ~clkPrev_q[1];
    assign lnk.rxClkRise = stable_q[WIDTH-2] & ~clkPrev_q[0];
    assign lnk.rxd = stable_q[9:6];
    assign lnk.rxDv = stable_q[5];
    assign lnk.crs = stable_q[4];
    assign lnk.col = stable_q[3];
    assign lnk.serRxData = stable_q[2];
    assign lnk.serCrs = stable_q[1];
    assign lnk.serCol = stable_q[0];
endmodule

/* hdl/mlp_port_ctrl.sv */
// Purpose: loopback, port select and duplex control for a 10/100 MAC
// Assumes: MAC engine on sys_clk; PHY and serial pins asynchronous
// Notes: registers reached over Avalon-MM with waitrequest
// Notes on behaviour
// (RQ1) Serial loopback only while loop bit set
// (RQ2) Serial internal loop: FIFO to FIFO, pins quiet
// (RQ3) Serial external loop transmits, collision stays live
// (RQ4) Software sets manual port select before MII loop
// (RQ5) Software loops PHY first, then device
// (RQ6) MII internal loop bit loops data port
// (RQ7) Loop nibble, clock, enable into receive side
// (RQ8) Loop carrier is transmit enable OR receive valid
// (RQ9) Transmit pins keep toggling; error pin never driven
// (RQ10) Padding and stripping unchanged in loopback
// (RQ11) Any loopback accepts runts; register bit untouched
// (RQ12) Descriptor status reports true FCS error
// (RQ13) FCS generation off while disable bit set
// (RQ14) Forced collision every attempt in internal loop
// (RQ15) MII after reset; serial code stops MII
// (RQ16) Full duplex by enable bit or negotiation
// (RQ17) Full duplex: transmit watermark alone requests DMA
// (RQ18) Full duplex: receive DMA at watermark or frame
// (RQ19) Full duplex: no deferral to receive activity
// (RQ20) Full duplex: gap timer starts at transmit end
// (RQ21) Full duplex: no blinding, SQE or collision; a forced collision in internal loop still reaches macCol
// (RQ22) Full duplex: no carrier loss; LED shows duplex
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module mlp_port_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] macTxd,
    input wire logic macTxEn,
    input wire logic macSerialTxBit,
    input wire logic macTxFirst64,
    input wire logic [7:0] txFifoFree,
    input wire logic [7:0] rxFifoLevel,
    input wire logic rxPast64,
    input wire logic rxFrameComplete,
    input wire logic rxFrameDone,
    input wire logic rxFcsBad,
    input wire logic phyFdNegotiated,
    output logic macTxClkEn,
    output logic macRxClkEn,
    output logic [3:0] macRxd,
    output logic macRxDv,
    output logic macRxSerialBit,
    output logic macCrs,
    output logic macCol,
    output logic fcsGenEnable,
    output logic runtAcceptInt,
    output logic deferOnReceive,
    output logic ipgStart,
    output logic sqeWindow,
    output logic lcarReportEnable,
    output logic txDmaReq,
    output logic rxDmaReq,
    output logic [31:0] rxDescStatus,
    output logic ledOut,
    input wire logic miiTxClk,
    input wire logic miiRxClk,
    input wire logic [3:0] miiRxd,
    input wire logic miiRxDv,
    input wire logic miiCrs,
    input wire logic miiCol,
    input wire logic serialRxData,
    input wire logic serialCrs,
    input wire logic serialCol,
    output logic [3:0] miiTxd,
    output logic miiTxEn,
    output logic miiTxEr,
    output logic serialTxData,
    output logic serialTxEn
);
    logic [31:0] avs_readdata_q, modeReg_q, miiReg_q, dupReg_q, fifoReg_q, ledReg_q, rdNext;
    logic [31:0] rxDescStatus_q;
    logic avs_waitrequest_q, fullDuplex_q, macTxClkEn_q, macRxClkEn_q;
    logic [3:0] macRxd_q, miiTxd_q;
    logic macRxDv_q, macRxSerialBit_q, macCrs_q, macCol_q, fcsGenEnable_q;
    logic runtAcceptInt_q, deferOnReceive_q, ipgStart_q, sqeWindow_q;
    logic lcarReportEnable_q, txDmaReq_q, rxDmaReq_q, ledOut_q;
    logic miiTxEn_q, miiTxEr_q, serialTxData_q, serialTxEn_q;
    logic actPrev_q, txEnPrev_q;
    logic [7:0] blindCnt_q;
    logic serialSel, serialIntLoop, miiIntLoop, anyLoop, internalLoop;
    logic forceCollNow, crsNow, colPin, activity, rxEarly, regWrite;
    logic [8:0] txThresh, rxThresh;

    mlp_link_if lnk ();

    mlp_pin_sync #(.WIDTH(12)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .miiTxClk(miiTxClk),
        .miiRxClk(miiRxClk),
        .miiRxd(miiRxd),
        .miiRxDv(miiRxDv),
        .miiCrs(miiCrs),
        .miiCol(miiCol),
        .serialRxData(serialRxData),
        .serialCrs(serialCrs),
        .serialCol(serialCol),
        .lnk(lnk)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Register bus: answer one cycle after the request, for one cycle
    assign regWrite = avs_write & ~avs_waitrequest_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q <= 32'h0000_0000;
        end else if ((avs_read | avs_write) & avs_waitrequest_q) begin
            avs_waitrequest_q <= 1'b0;
            avs_readdata_q <= avs_read ? rdNext : 32'h0000_0000;
        end else begin
            avs_waitrequest_q <= 1'b1;
        end
    end

    // Runt-accept bit keeps its software value; loopback only widens it internally
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            modeReg_q <= mlp_pkg::MODE_RST; // RQ15
            miiReg_q <= mlp_pkg::MII_RST;
            dupReg_q <= mlp_pkg::DUP_RST;
            fifoReg_q <= mlp_pkg::FIFO_RST;
            ledReg_q <= mlp_pkg::LED_RST;
        end else if (regWrite) begin
            case (avs_address)
                mlp_pkg::OFF_MODE: modeReg_q <= avs_writedata & mlp_pkg::MODE_MASK;
                mlp_pkg::OFF_MII: miiReg_q <= avs_writedata & mlp_pkg::MII_MASK;
                mlp_pkg::OFF_DUPLEX: dupReg_q <= avs_writedata & mlp_pkg::DUP_MASK;
                mlp_pkg::OFF_FIFO: fifoReg_q <= avs_writedata & mlp_pkg::FIFO_MASK;
                mlp_pkg::OFF_LED: ledReg_q <= avs_writedata & mlp_pkg::LED_MASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (avs_address)
            mlp_pkg::OFF_MODE: rdNext = modeReg_q;
            mlp_pkg::OFF_MII: rdNext = miiReg_q;
            mlp_pkg::OFF_DUPLEX: rdNext = dupReg_q;
            mlp_pkg::OFF_FIFO: rdNext = fifoReg_q;
            mlp_pkg::OFF_LED: rdNext = ledReg_q;
            mlp_pkg::OFF_STATUS: rdNext = {26'h0, ledOut_q, runtAcceptInt_q, internalLoop,
                                           miiIntLoop, serialIntLoop, fullDuplex_q};
            default: rdNext = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign serialSel = modeReg_q[mlp_pkg::MODE_PSEL_HI:mlp_pkg::MODE_PSEL_LO]
                       == mlp_pkg::PSEL_SERIAL; // RQ15
    assign serialIntLoop = serialSel & modeReg_q[mlp_pkg::MODE_LOOP_BIT]
                           & modeReg_q[mlp_pkg::MODE_INTERNAL_LOOP_SELECT_BIT]; // RQ1 RQ2
    // Management pins are not in this block, so the loop cannot touch them
    assign miiIntLoop = ~serialSel & miiReg_q[mlp_pkg::MII_LOOP_BIT]; // RQ6
    assign anyLoop = modeReg_q[mlp_pkg::MODE_LOOP_BIT] | miiIntLoop;
    assign internalLoop = serialIntLoop | miiIntLoop;
    assign forceCollNow = internalLoop & modeReg_q[mlp_pkg::MODE_FORCE_COLLISION_BIT] & macTxEn; // RQ14

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fullDuplex_q <= 1'b0;
        end else begin
            fullDuplex_q <= dupReg_q[mlp_pkg::DUP_FULL_DUPLEX_ENABLE_BIT]
                            | (~serialSel & dupReg_q[mlp_pkg::DUP_AUTO_PORT_SELECT_BIT]
                               & ~miiReg_q[mlp_pkg::MII_ANDIS_BIT] & phyFdNegotiated); // RQ16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            miiTxd_q <= 4'h0;
            miiTxEn_q <= 1'b0;
            miiTxEr_q <= 1'b0;
        end else if (serialSel) begin
            miiTxd_q <= 4'h0; // RQ15
            miiTxEn_q <= 1'b0;
            miiTxEr_q <= 1'b0;
        end else if (lnk.txClkRise) begin
            miiTxd_q <= macTxd; // RQ9
            miiTxEn_q <= macTxEn;
            miiTxEr_q <= 1'b0; // RQ9
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serialTxData_q <= 1'b0;
            serialTxEn_q <= 1'b0;
        end else if (~serialSel | serialIntLoop) begin
            serialTxData_q <= 1'b0; // RQ2
            serialTxEn_q <= 1'b0;
        end else if (lnk.txClkRise) begin
            serialTxData_q <= macSerialTxBit; // RQ3
            serialTxEn_q <= macTxEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path toward the MAC; the loop uses the same nibble the pins get
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            macTxClkEn_q <= 1'b0;
            macRxClkEn_q <= 1'b0;
        end else begin
            macTxClkEn_q <= lnk.txClkRise;
            macRxClkEn_q <= miiIntLoop ? lnk.txClkRise : lnk.rxClkRise; // RQ7
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            macRxd_q <= 4'h0;
            macRxDv_q <= 1'b0;
            macRxSerialBit_q <= 1'b0;
        end else if (serialSel) begin
            macRxd_q <= 4'h0;
            macRxSerialBit_q <= serialIntLoop ? macSerialTxBit : lnk.serRxData; // RQ2
            macRxDv_q <= serialIntLoop ? macTxEn : lnk.serCrs;
        end else if (miiIntLoop) begin
            if (lnk.txClkRise) begin
                macRxd_q <= macTxd; // RQ7
                macRxDv_q <= macTxEn;
            end
        end else if (lnk.rxClkRise) begin
            macRxd_q <= lnk.rxd;
            macRxDv_q <= lnk.rxDv;
        end
    end

    always_comb begin
        if (serialSel) begin
            crsNow = serialIntLoop ? macTxEn : lnk.serCrs;
            colPin = serialIntLoop ? 1'b0 : lnk.serCol; // RQ2 RQ3
        end else begin
            crsNow = miiIntLoop ? (miiTxEn_q | macRxDv_q) : lnk.crs; // RQ8
            colPin = miiIntLoop ? 1'b0 : lnk.col;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            macCrs_q <= 1'b0;
            macCol_q <= 1'b0;
        end else begin
            macCrs_q <= crsNow;
            macCol_q <= forceCollNow | (~fullDuplex_q & colPin); // RQ14 RQ21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine controls; padding and stripping are left to the engine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fcsGenEnable_q <= 1'b1;
            runtAcceptInt_q <= 1'b0;
            deferOnReceive_q <= 1'b1;
            lcarReportEnable_q <= 1'b1;
            ledOut_q <= 1'b0;
        end else begin
            fcsGenEnable_q <= ~modeReg_q[mlp_pkg::MODE_FCS_DIS_BIT]; // RQ13
            runtAcceptInt_q <= fifoReg_q[mlp_pkg::FIFO_RUNT_BIT] | anyLoop; // RQ10 RQ11
            deferOnReceive_q <= ~fullDuplex_q; // RQ19
            lcarReportEnable_q <= ~fullDuplex_q; // RQ22
            ledOut_q <= ledReg_q[mlp_pkg::LED_FDSEL_BIT] & fullDuplex_q; // RQ22
        end
    end

    // Half duplex waits for carrier too; full duplex only for own transmit
    assign activity = macTxEn | (~fullDuplex_q & crsNow); // RQ20

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            actPrev_q <= 1'b0;
            ipgStart_q <= 1'b0;
        end else begin
            actPrev_q <= activity;
            ipgStart_q <= actPrev_q & ~activity; // RQ20
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txEnPrev_q <= 1'b0;
            blindCnt_q <= 8'h00;
            sqeWindow_q <= 1'b0;
        end else begin
            txEnPrev_q <= macTxEn;
            if (fullDuplex_q) begin
                blindCnt_q <= 8'h00; // RQ21
                sqeWindow_q <= 1'b0;
            end else if (txEnPrev_q & ~macTxEn) begin
                blindCnt_q <= 8'(mlp_pkg::BLIND_CYCLES);
                sqeWindow_q <= 1'b1;
            end else if (blindCnt_q != 8'h00) begin
                blindCnt_q <= blindCnt_q - 8'h01;
                sqeWindow_q <= blindCnt_q != 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA requests; half duplex keeps 64 bytes back for retry
    assign txThresh = 9'(({7'h00, fifoReg_q[mlp_pkg::FIFO_TXWM_HI:mlp_pkg::FIFO_TXWM_LO]}
                          + 9'h001) << mlp_pkg::WM_SHIFT);
    assign rxThresh = 9'(({7'h00, fifoReg_q[mlp_pkg::FIFO_RXWM_HI:mlp_pkg::FIFO_RXWM_LO]}
                          + 9'h001) << mlp_pkg::WM_SHIFT);
    assign rxEarly = fullDuplex_q | runtAcceptInt_q; // RQ18

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txDmaReq_q <= 1'b0;
            rxDmaReq_q <= 1'b0;
        end else begin
            txDmaReq_q <= {1'b0, txFifoFree} >= (txThresh
                          + ((~fullDuplex_q & macTxFirst64) ? mlp_pkg::MIN_FRAME_BYTES
                                                           : 9'h000)); // RQ17
            rxDmaReq_q <= (rxEarly | rxPast64)
                          & (({1'b0, rxFifoLevel} >= rxThresh) | rxFrameComplete); // RQ18
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxDescStatus_q <= 32'h0000_0000;
        end else if (rxFrameDone) begin
            rxDescStatus_q <= 32'h0000_0000;
            rxDescStatus_q[mlp_pkg::DESC_FCS_BIT] <= rxFcsBad; // RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_txEndHalf;
        !fullDuplex_q && txEnPrev_q && !macTxEn;
    endsequence

    a_blind_window: assert property (s_txEndHalf ##1 !fullDuplex_q[*8] |-> sqeWindow_q[*1]) // RQ21
        else $error("blinding window missing after transmit");
    a_fd_no_blind: assert property (fullDuplex_q |=> !sqeWindow_q) // RQ21
        else $error("blinding active in full duplex");
    a_fd_col_gate: assert property (fullDuplex_q && !forceCollNow |=> !macCol_q) // RQ21
        else $error("collision passed in full duplex");
    a_force_coll: assert property (forceCollNow |=> macCol_q) // RQ14
        else $error("forced collision not seen");
    a_serial_quiet: assert property (serialIntLoop |=> !serialTxEn_q && !serialTxData_q) // RQ2
        else $error("serial pins active in internal loop");
    a_mii_stopped: assert property (serialSel |=> !miiTxEn_q && miiTxd_q == 4'h0) // RQ15
        else $error("MII driven while serial selected");
    a_mii_loop: assert property (miiIntLoop && lnk.txClkRise |=> // RQ7
                                 macRxd_q == miiTxd_q && macRxDv_q == miiTxEn_q)
        else $error("loop nibble mismatch");
    a_loop_crs: assert property (miiIntLoop && miiTxEn_q |=> macCrs_q) // RQ8
        else $error("carrier dropped during looped frame");
    a_loop_runt: assert property (anyLoop |=> runtAcceptInt_q) // RQ11
        else $error("runt accept not forced in loopback");
    a_fcs_off: assert property (modeReg_q[mlp_pkg::MODE_FCS_DIS_BIT] |=> !fcsGenEnable_q) // RQ13
        else $error("FCS generation not disabled");
    a_fd_rx_dma: assert property (fullDuplex_q && rxFrameComplete |=> rxDmaReq_q) // RQ18
        else $error("receive DMA late in full duplex");
    a_fd_ipg: assert property (fullDuplex_q && $past(fullDuplex_q) && $fell(macTxEn) // RQ20
                               |=> ipgStart_q)
        else $error("gap timer not started at transmit end");
    a_fd_nodefer: assert property (fullDuplex_q |=> // RQ19
                                   !deferOnReceive_q && !lcarReportEnable_q)
        else $error("deferral or carrier loss left on");
    a_fd_led: assert property (fullDuplex_q && ledReg_q[mlp_pkg::LED_FDSEL_BIT] |=> // RQ22
                               ledOut_q)
        else $error("duplex LED not lit");

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign avs_readdata = avs_readdata_q;
    assign avs_waitrequest = avs_waitrequest_q;
    assign macTxClkEn = macTxClkEn_q;
    assign macRxClkEn = macRxClkEn_q;
    assign macRxd = macRxd_q;
    assign macRxDv = macRxDv_q;
    assign macRxSerialBit = macRxSerialBit_q;
    assign macCrs = macCrs_q;
    assign macCol = macCol_q;
    assign fcsGenEnable = fcsGenEnable_q;
    assign runtAcceptInt = runtAcceptInt_q;
    assign deferOnReceive = deferOnReceive_q;
    assign ipgStart = ipgStart_q;
    assign sqeWindow = sqeWindow_q;
    assign lcarReportEnable = lcarReportEnable_q;
    assign txDmaReq = txDmaReq_q;
    assign rxDmaReq = rxDmaReq_q;
    assign rxDescStatus = rxDescStatus_q;
    assign ledOut = ledOut_q;
    assign miiTxd = miiTxd_q;
    assign miiTxEn = miiTxEn_q;
    assign miiTxEr = miiTxEr_q;
    assign serialTxData = serialTxData_q;
    assign serialTxEn = serialTxEn_q;
endmodule

/* include/mlp_link_if.sv */
// Purpose: synchronised line-side signals passed to the port control core
// Assumes: all members are on sys_clk
// Notes: clock members are one-cycle rising-edge pulses
`timescale 1ns/100ps
interface mlp_link_if;
    logic txClkRise;
    logic rxClkRise;
    logic [3:0] rxd;
    logic rxDv;
    logic crs;
    logic col;
    logic serRxData;
    logic serCrs;
    logic serCol;
    modport src (output txClkRise, rxClkRise, rxd, rxDv, crs, col, serRxData, serCrs, serCol);
    modport dst (input txClkRise, rxClkRise, rxd, rxDv, crs, col, serRxData, serCrs, serCol);
endinterface

/* include/mlp_pkg.sv */
// Purpose: shared constants for the network port control block
// Assumes: sys_clk at 20 MHz; Avalon-MM word addressing
// Notes: register index times four is the byte address
package mlp_pkg;
    // Register indices (word addresses)
    localparam logic [3:0] OFF_MODE = 4'h0;
    localparam logic [3:0] OFF_MII = 4'h1;
    localparam logic [3:0] OFF_DUPLEX = 4'h2;
    localparam logic [3:0] OFF_FIFO = 4'h3;
    localparam logic [3:0] OFF_LED = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;
    // Mode register fields
    localparam int MODE_LOOP_BIT = 2;
    localparam int MODE_FCS_DIS_BIT = 3;
    localparam int MODE_FORCE_COLLISION_BIT = 4;
    localparam int MODE_INTERNAL_LOOP_SELECT_BIT = 6;
    localparam int MODE_PSEL_LO = 7;
    localparam int MODE_PSEL_HI = 8;
    localparam logic [1:0] PSEL_SERIAL = 2'h2;
    // MII control register fields
    localparam int MII_LOOP_BIT = 1;
    localparam int MII_ANDIS_BIT = 7;
    // Duplex control register fields
    localparam int DUP_FULL_DUPLEX_ENABLE_BIT = 0;
    localparam int DUP_AUTO_PORT_SELECT_BIT = 1;
    // FIFO threshold register fields
    localparam int FIFO_RUNT_BIT = 3;
    localparam int FIFO_TXWM_LO = 8;
    localparam int FIFO_TXWM_HI = 9;
    localparam int FIFO_RXWM_LO = 12;
    localparam int FIFO_RXWM_HI = 13;
    localparam int WM_SHIFT = 4;
    // LED register field
    localparam int LED_FDSEL_BIT = 8;
    // Receive descriptor status word
    localparam int DESC_FCS_BIT = 27;
    // Writable masks, reserved bits read zero
    localparam logic [31:0] MODE_MASK = 32'h0000_01DC;
    localparam logic [31:0] MII_MASK = 32'h0000_0082;
    localparam logic [31:0] DUP_MASK = 32'h0000_0003;
    localparam logic [31:0] FIFO_MASK = 32'h0000_3308;
    localparam logic [31:0] LED_MASK = 32'h0000_0100;
    // Reset values: pins come up as MII, automatic selection on
    localparam logic [31:0] MODE_RST = 32'h0000_0180;
    localparam logic [31:0] MII_RST = 32'h0000_0000;
    localparam logic [31:0] DUP_RST = 32'h0000_0002;
    localparam logic [31:0] FIFO_RST = 32'h0000_0000;
    localparam logic [31:0] LED_RST = 32'h0000_0000;
    // Timing
    localparam int CLK_MHZ = 20;
    localparam int BLIND_TIME_NS = 4000;
    localparam int BLIND_CYCLES = (BLIND_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [8:0] MIN_FRAME_BYTES = 9'h040;
endpackage

/* test/mlp_phy_model.sv */
// Purpose: PHY and serial codec stand-in at the line pins
// Assumes: PHY clocks 2.5 MHz, free running as on a real MII
// Notes: PHY sits in loopback; idle lines show a changing pattern
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module mlp_phy_model (
    input wire logic [3:0] miiTxd,
    input wire logic miiTxEn,
    input wire logic serialTxData,
    input wire logic serialTxEn,
    input wire logic colIn,
    output logic miiTxClk,
    output logic miiRxClk,
    output logic [3:0] miiRxd,
    output logic miiRxDv,
    output logic miiCrs,
    output logic miiCol,
    output logic serialRxData,
    output logic serialCrs,
    output logic serialCol
);
    initial begin
        miiTxClk = 1'b0;
        miiRxd = 4'h5;
        miiRxDv = 1'b0;
        serialRxData = 1'b0;
    end
    always #200 miiTxClk = ~miiTxClk;
    // Rx clock out of phase with tx, as a PHY may send it
    assign #70 miiRxClk = miiTxClk;
    always @(posedge miiRxClk) begin
        miiRxd <= miiTxEn ? miiTxd : ~miiRxd;
        miiRxDv <= miiTxEn;
        serialRxData <= serialTxEn ? serialTxData : ~serialRxData;
    end
    assign miiCrs = miiRxDv;
    assign miiCol = colIn & miiTxEn;
    assign serialCrs = serialTxEn;
    assign serialCol = colIn & serialTxEn;
endmodule

/* test/mlp_port_ctrl_tb.sv */
// Purpose: self-checking bench for the port control block
// Assumes: 20 MHz sys_clk; engine status inputs random each cycle, except rxFrameDone and rxFcsBad
// Notes: registers reached only through the bus task
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////
module mlp_port_ctrl_tb;
    logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, macTxEn = 1'b0;
    logic [3:0] avs_address = 4'h0, macTxd = 4'h0, miiRxd, miiTxd, macRxd;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rxDescStatus, rd, rnd;
    logic macSerialTxBit, macTxFirst64, rxPast64, rxFrameComplete, phyFdNegotiated;
    logic [7:0] txFifoFree, rxFifoLevel;
    logic rxFrameDone = 1'b0, rxFcsBad = 1'b0, colIn = 1'b0;
    logic avs_waitrequest, macTxClkEn, macRxClkEn, macRxDv, macRxSerialBit, macCrs, macCol;
    logic fcsGenEnable, runtAcceptInt, deferOnReceive, ipgStart, sqeWindow, lcarReportEnable;
    logic txDmaReq, rxDmaReq, ledOut, miiTxClk, miiRxClk, miiRxDv, miiCrs, miiCol;
    logic serialRxData, serialCrs, serialCol, miiTxEn, miiTxEr, serialTxData, serialTxEn;
    int fails = 0, num_checks = 0;
    always #25 sys_clk = ~sys_clk;
    mlp_port_ctrl DUT (.*);
    mlp_phy_model phy (.*);
    initial {macSerialTxBit, macTxFirst64, rxPast64, rxFrameComplete, phyFdNegotiated,
        txFifoFree, rxFifoLevel} = 21'h0;
    always @(posedge sys_clk) {macSerialTxBit, macTxFirst64, rxPast64, rxFrameComplete,
        phyFdNegotiated, txFifoFree, rxFifoLevel} <= 21'($urandom);
    ////////////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // PHY edges are rare, so wait for the looped receive strobe
    task automatic rxEdge;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (macRxClkEn !== 1'b1 && n < 40);
        if (macRxClkEn !== 1'b1) fails++;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        close_out;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hD9EF5E20));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(mlp_pkg::OFF_MODE, mlp_pkg::MODE_RST);
        rdchk(mlp_pkg::OFF_DUPLEX, mlp_pkg::DUP_RST);
        rdchk(4'hF, 32'h0);
        `CHK(miiTxEr, 1'b0)
        bus(1'b1, mlp_pkg::OFF_MODE, 32'h8);
        `CHK(fcsGenEnable, 1'b0)
        rnd = $urandom & ~32'h8;
        bus(1'b1, mlp_pkg::OFF_FIFO, rnd);
        bus(1'b1, mlp_pkg::OFF_DUPLEX, 32'h0);
        // Duplex is registered, then the defer flag: two edges after the write
        @(posedge sys_clk);
        `CHK(deferOnReceive, 1'b1)
        $display("test reset and fields done");
        bus(1'b1, mlp_pkg::OFF_MII, 32'h2);
        macTxEn <= 1'b1;
        // First strobe may still carry the idle nibble
        rxEdge;
        for (int i = 0; i < 6; i++) begin
            macTxd <= 4'($urandom);
            rxEdge;
            `CHK(macRxd, macTxd)
            `CHK(macTxClkEn, 1'b1)
            `CHK(miiTxd, macTxd)
            `CHK(macCrs & macRxDv, 1'b1)
        end
        `CHK(runtAcceptInt, 1'b1)
        rdchk(mlp_pkg::OFF_FIFO, rnd & mlp_pkg::FIFO_MASK);
        bus(1'b1, mlp_pkg::OFF_MODE, 32'h10);
        `CHK(macCol, 1'b1)
        bus(1'b1, mlp_pkg::OFF_MII, 32'h0);
        macTxEn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(sqeWindow, 1'b1)
        macTxEn <= 1'b1;
        $display("test MII loop done");
        colIn <= 1'b1;
        bus(1'b1, mlp_pkg::OFF_DUPLEX, 32'h1);
        bus(1'b1, mlp_pkg::OFF_LED, 32'h100);
        `CHK({deferOnReceive, lcarReportEnable, ledOut}, 3'h1)
        `CHK({macCol, sqeWindow}, 2'h0)
        // Largest watermark is 64 bytes, so 64 free always requests in full duplex
        do @(posedge sys_clk); while (!(rxFrameComplete === 1'b1 && txFifoFree >= 8'h40));
        @(posedge sys_clk);
        `CHK({rxDmaReq, txDmaReq}, 2'h3)
        macTxEn <= 1'b0;
        rxFrameDone <= 1'b1;
        rxFcsBad <= 1'b1;
        @(posedge sys_clk);
        rxFrameDone <= 1'b0;
        @(posedge sys_clk);
        `CHK(rxDescStatus[27], 1'b1)
        `CHK(ipgStart, 1'b1)
        bus(1'b1, mlp_pkg::OFF_MODE, 32'h144);
        repeat (30) @(posedge sys_clk);
        `CHK({miiTxEn, miiTxd}, 5'h0)
        `CHK({serialTxEn, serialTxData}, 2'h0)
        $display("test duplex and serial done");
        close_out;
    end
endmodule
